/* hw/dbgsp_top.sv */
// debug serial port: control register, transmitter and receiver
module dbgsp_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // baud sources from the timers
    input wire logic t1_ovf_i,
    input wire logic t2_ovf_i,
    input wire logic tx_second_general_timer_i,
    input wire logic rx_second_general_timer_i,
    input wire logic rate_double_i,
    // serial pins
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe_o,
    output logic txd_o
);
    typedef struct packed {
        logic [1:0] mode;
        logic mpf;
        logic ren;
        logic tb8;
        logic rb8;
        logic ti;
        logic ri;
        logic [10:0] tx_frame;
        dbgsp_pkg::dbgsp_tx_e tx_st;
        logic [3:0] tx_idx;
        logic [3:0] tx_cnt;
        dbgsp_pkg::dbgsp_rx_e rx_st;
        logic [3:0] rx_idx;
        logic [3:0] rx_cnt;
        logic [7:0] rx_shift;
        logic rx_bit9;
        logic [7:0] rx_buf;
        logic rx_prev;
        logic [2:0] ph;
        logic txd;
        logic rxd_out;
        logic rxd_oe;
        logic [7:0] rdata;
    } dbgsp_core_s;

    dbgsp_core_s s_q, s_d;
    dbgsp_tick_if tick_if ();

    logic wr_ctrl;
    logic wr_data;
    logic nine_bit;
    logic ph_end;
    logic set_ti;
    logic set_ri;
    logic load_rb8;
    logic load_buf;
    logic pass;

    dbgsp_rate_gen u_rate (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .mode_i(s_q.mode),
        .rate_double_i(rate_double_i),
        .tx_second_general_timer_i(tx_second_general_timer_i),
        .rx_second_general_timer_i(rx_second_general_timer_i),
        .t1_ovf_i(t1_ovf_i),
        .t2_ovf_i(t2_ovf_i),
        .tick(tick_if.gen)
    );

    assign wr_ctrl = sfr_wr_i & (sfr_addr_i == dbgsp_pkg::CTRL_ADDR);
    assign wr_data = sfr_wr_i & (sfr_addr_i == dbgsp_pkg::DATA_ADDR);
    assign nine_bit = s_q.mode[1];
    assign ph_end = (s_q.ph == dbgsp_pkg::M0_PH_LAST);

    // frame acceptance by the multiprocessor filter
    always_comb begin
        pass = 1'b1;
        if (s_q.mpf && nine_bit && !s_q.rx_bit9) begin
            pass = 1'b0;
        end
        if (s_q.mpf && s_q.mode == dbgsp_pkg::MODE_8VAR
            && !s_q.rx_bit9) begin
            pass = 1'b0;
        end
    end

    always_comb begin
        s_d = s_q;
        set_ti = 1'b0;
        set_ri = 1'b0;
        load_rb8 = 1'b0;
        load_buf = 1'b0;

        // shared six-phase counter for mode 0 machine cycles
        s_d.ph = ph_end ? 3'h0 : s_q.ph + 3'h1;

        // transmitter
        case (s_q.tx_st)
            dbgsp_pkg::TX_ASYNC: begin
                if (tick_if.tx_tick) begin
                    s_d.tx_cnt = s_q.tx_cnt + 4'h1;
                    if (s_q.tx_cnt == dbgsp_pkg::TICK_LAST) begin
                        s_d.tx_idx = s_q.tx_idx + 4'h1;
                        if (nine_bit
                            && s_q.tx_idx == dbgsp_pkg::TX_TI_IDX_9) begin
                            set_ti = 1'b1;
                        end
                        if (!nine_bit
                            && s_q.tx_idx == dbgsp_pkg::TX_TI_IDX_8) begin
                            set_ti = 1'b1;
                        end
                        if (s_q.tx_idx == (nine_bit
                            ? dbgsp_pkg::TX_END_IDX_9
                            : dbgsp_pkg::TX_END_IDX_8)) begin
                            s_d.tx_st = dbgsp_pkg::TX_IDLE;
                        end
                    end
                end
                // the index runs past the frame once the stop bit ends
                if (s_d.tx_st == dbgsp_pkg::TX_IDLE) begin
                    s_d.txd = 1'b1;
                end else begin
                    s_d.txd = s_d.tx_frame[s_d.tx_idx];
                end
            end
            dbgsp_pkg::TX_SHIFT: begin
                // data on rx pin, shift clock low then high on tx pin
                s_d.rxd_out = s_q.tx_frame[s_q.tx_idx];
                s_d.txd = (s_d.ph >= dbgsp_pkg::M0_PH_RISE);
                if (ph_end) begin
                    s_d.tx_idx = s_q.tx_idx + 4'h1;
                    if (s_q.tx_idx == dbgsp_pkg::M0_TX_LAST) begin
                        set_ti = 1'b1;
                        s_d.tx_st = dbgsp_pkg::TX_IDLE;
                        s_d.rxd_oe = 1'b0;
                        s_d.txd = 1'b1;
                    end else begin
                        s_d.rxd_out = s_q.tx_frame[s_d.tx_idx];
                    end
                end
            end
            default: begin
                s_d.txd = 1'b1;
                s_d.rxd_oe = 1'b0;
            end
        endcase

        // any buffer write restarts the transmitter with the new byte
        if (wr_data) begin
            s_d.tx_idx = 4'h0;
            s_d.tx_cnt = 4'h0;
            s_d.ph = 3'h0;
            if (s_q.mode == dbgsp_pkg::MODE_SHIFT) begin
                s_d.tx_st = dbgsp_pkg::TX_SHIFT;
                s_d.tx_frame = {3'h7, sfr_wdata_i};
                s_d.rxd_out = sfr_wdata_i[0];
                s_d.rxd_oe = 1'b1;
                s_d.txd = 1'b0;
            end else begin
                s_d.tx_st = dbgsp_pkg::TX_ASYNC;
                // stop, ninth (or second stop), data lsb first, start
                s_d.tx_frame = {1'b1, nine_bit ? s_q.tb8 : 1'b1,
                                sfr_wdata_i, 1'b0};
                s_d.txd = 1'b0;
            end
        end

        // receiver
        s_d.rx_prev = rxd_i;
        case (s_q.rx_st)
            dbgsp_pkg::RX_IDLE: begin
                if (s_q.mode == dbgsp_pkg::MODE_SHIFT) begin
                    // pin is shared, so wait for the transmitter
                    if (s_q.ren && !s_q.ri
                        && s_q.tx_st == dbgsp_pkg::TX_IDLE
                        && !wr_data) begin
                        s_d.rx_st = dbgsp_pkg::RX_SHIFT;
                        s_d.rx_idx = 4'h0;
                        s_d.ph = 3'h0;
                    end
                end else if (s_q.ren && s_q.rx_prev && !rxd_i) begin
                    s_d.rx_st = dbgsp_pkg::RX_ASYNC;
                    s_d.rx_idx = 4'h0;
                    s_d.rx_cnt = 4'h0;
                end
            end
            dbgsp_pkg::RX_ASYNC: begin
                if (tick_if.rx_tick) begin
                    s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                    if (s_q.rx_cnt == dbgsp_pkg::TICK_SAMPLE) begin
                        if (s_q.rx_idx == 4'h0) begin
                            // a start bit gone high is a glitch
                            if (rxd_i) begin
                                s_d.rx_st = dbgsp_pkg::RX_IDLE;
                            end
                        end else if (s_q.rx_idx == dbgsp_pkg::RX_END_IDX)
                        begin
                            // ninth bit in 9-bit modes, stop in 8-bit
                            s_d.rx_bit9 = rxd_i;
                            s_d.rx_st = dbgsp_pkg::RX_DONE;
                        end else begin
                            s_d.rx_shift = {rxd_i, s_q.rx_shift[7:1]};
                        end
                    end
                    if (s_q.rx_cnt == dbgsp_pkg::TICK_LAST) begin
                        s_d.rx_idx = s_q.rx_idx + 4'h1;
                    end
                end
            end
            dbgsp_pkg::RX_SHIFT: begin
                if (s_q.ph == dbgsp_pkg::M0_PH_RISE
                    && s_q.rx_idx != 4'h0
                    && s_q.rx_idx != dbgsp_pkg::M0_RX_DONE_IDX) begin
                    s_d.rx_shift = {rxd_i, s_q.rx_shift[7:1]};
                end
                if (ph_end) begin
                    s_d.rx_idx = s_q.rx_idx + 4'h1;
                end
                // clock follows the cycle being entered, high in cycles 0 and 9
                s_d.txd = (s_d.ph >= dbgsp_pkg::M0_PH_RISE)
                          || s_d.rx_idx == 4'h0
                          || s_d.rx_idx == dbgsp_pkg::M0_RX_DONE_IDX;
                if (s_q.rx_idx == dbgsp_pkg::M0_RX_DONE_IDX
                    && s_q.ph == dbgsp_pkg::M0_RI_PH) begin
                    s_d.rx_st = dbgsp_pkg::RX_DONE;
                    s_d.txd = 1'b1;
                end
            end
            dbgsp_pkg::RX_DONE: begin
                s_d.rx_st = dbgsp_pkg::RX_IDLE;
                // an unread byte is kept, the new one is dropped
                if (!s_q.ri) begin
                    if (s_q.mode == dbgsp_pkg::MODE_SHIFT) begin
                        set_ri = 1'b1;
                        load_buf = 1'b1;
                    end else if (pass) begin
                        set_ri = 1'b1;
                        load_buf = 1'b1;
                        load_rb8 = 1'b1;
                    end
                end
            end
            default: begin
                s_d.rx_st = dbgsp_pkg::RX_IDLE;
            end
        endcase
        if (load_buf) begin
            s_d.rx_buf = s_q.rx_shift;
        end

        // control register; hardware updates win over the write
        if (wr_ctrl) begin
            s_d.mode = sfr_wdata_i[dbgsp_pkg::MODE_HI_BIT:
                                   dbgsp_pkg::MODE_LO_BIT];
            s_d.mpf = sfr_wdata_i[dbgsp_pkg::MPF_BIT];
            s_d.ren = sfr_wdata_i[dbgsp_pkg::REN_BIT];
            s_d.tb8 = sfr_wdata_i[dbgsp_pkg::TB8_BIT];
            s_d.rb8 = sfr_wdata_i[dbgsp_pkg::RB8_BIT];
            s_d.ti = sfr_wdata_i[dbgsp_pkg::TI_BIT];
            s_d.ri = sfr_wdata_i[dbgsp_pkg::RI_BIT];
        end
        if (load_rb8) begin
            s_d.rb8 = s_q.rx_bit9;
        end
        if (set_ti) begin
            s_d.ti = 1'b1;
        end
        if (set_ri) begin
            s_d.ri = 1'b1;
        end

        // read data is registered, valid the cycle after the strobe
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                dbgsp_pkg::CTRL_ADDR: begin
                    s_d.rdata = {s_q.mode, s_q.mpf, s_q.ren,
                                 s_q.tb8, s_q.rb8, s_q.ti, s_q.ri};
                end
                dbgsp_pkg::DATA_ADDR: begin
                    s_d.rdata = s_q.rx_buf;
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.mode <= dbgsp_pkg::CTRL_RESET[dbgsp_pkg::MODE_HI_BIT:
                                             dbgsp_pkg::MODE_LO_BIT];
            s_q.tx_st <= dbgsp_pkg::TX_IDLE;
            s_q.rx_st <= dbgsp_pkg::RX_IDLE;
            s_q.rx_buf <= dbgsp_pkg::DATA_RESET;
            s_q.rx_prev <= 1'b1;
            s_q.txd <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata_o = s_q.rdata;
    assign rxd_o = s_q.rxd_out;
    assign rxd_oe_o = s_q.rxd_oe;
    assign txd_o = s_q.txd;
endmodule // dbgsp_top

/* hw/dbgsp_pkg.sv */
// constants and types shared by the debug serial port design
// Overview of operation
// - 9-bit variable mode: start, 8 data, ninth, stop
// - 9-bit modes send tx_ninth_bit as ninth bit
// - rx_ninth_bit gets ninth or stop; mode 0 keeps
// - variable 9-bit mode timed by timer overflows
// - any buffer write starts a transmission
// - mode 0 receives when done clear, enable set
// - async modes receive on start bit if enabled
// - bits 7..6 select mode, firmware written
// - filter drops 9-bit frames with ninth bit zero
// - filter drops 8-bit frames without valid stop
// - filter clear or mode 0: no effect
// - bit 4 enables reception, firmware written
// - 9-bit modes: tx done after ninth bit
// - mode 0 and 8-bit: tx done after eighth bit
// - 9-bit rx done one clock after ninth sample
// - 8-bit rx done one clock after stop sample
// - mode 0 rx done, state 1 tenth cycle
// - hardware updates win over firmware writes
// - mode 0 shifts on rx pin, clock clk/6
// - 8-bit mode: start, 8 data, stop
// - second byte lost while first unread
// - buffer write loads tx, read returns rx
package dbgsp_pkg;
    localparam int CLK_HZ = 20_000_000;
    // register addresses on the special function bus
    localparam logic [7:0] CTRL_ADDR = 8'h98;
    localparam logic [7:0] DATA_ADDR = 8'h99;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // control register field positions
    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int MPF_BIT = 5;
    localparam int REN_BIT = 4;
    localparam int TB8_BIT = 3;
    localparam int RB8_BIT = 2;
    localparam int TI_BIT = 1;
    localparam int RI_BIT = 0;
    // mode encodings
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_8VAR = 2'h1;
    localparam logic [1:0] MODE_9FIX = 2'h2;
    localparam logic [1:0] MODE_9VAR = 2'h3;
    // async bit timing, 16 ticks per bit
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_SAMPLE = 4'h7;
    localparam logic [3:0] TX_TI_IDX_8 = 4'h8;
    localparam logic [3:0] TX_TI_IDX_9 = 4'h9;
    localparam logic [3:0] TX_END_IDX_8 = 4'h9;
    localparam logic [3:0] TX_END_IDX_9 = 4'hA;
    localparam logic [3:0] RX_END_IDX = 4'h9;
    // mode 0 machine cycle of six clock phases
    localparam logic [2:0] M0_PH_LAST = 3'h5;
    localparam logic [2:0] M0_PH_RISE = 3'h3;
    localparam logic [2:0] M0_RI_PH = 3'h1;
    localparam logic [3:0] M0_TX_LAST = 4'h7;
    localparam logic [3:0] M0_RX_DONE_IDX = 4'h9;
    // fixed mode prescaler limits: tick at clk/4 or clk/2
    localparam logic [1:0] FIX_PRE_SLOW = 2'h3;
    localparam logic [1:0] FIX_PRE_FAST = 2'h1;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_ASYNC = 3'b010,
        TX_SHIFT = 3'b100
    } dbgsp_tx_e;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_ASYNC = 4'b0010,
        RX_SHIFT = 4'b0100,
        RX_DONE  = 4'b1000
    } dbgsp_rx_e;
endpackage

/* hw/dbgsp_tick_if.sv */
// oversampling tick pulses from the rate generator to the core
interface dbgsp_tick_if;
    logic tx_tick;
    logic rx_tick;
    modport gen (output tx_tick, output rx_tick);
    modport core (input tx_tick, input rx_tick);
endinterface

/* hw/dbgsp_rate_gen.sv */
// bit-rate tick generator, sixteen ticks per bit
module dbgsp_rate_gen (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // configuration
    input wire logic [1:0] mode_i,
    input wire logic rate_double_i,
    input wire logic tx_second_general_timer_i,
    input wire logic rx_second_general_timer_i,
    // timer overflow pulses
    input wire logic t1_ovf_i,
    input wire logic t2_ovf_i,
    // ticks out
    dbgsp_tick_if.gen tick
);
    typedef struct packed {
        logic [1:0] pre;
        logic t1_tx_half;
        logic t1_rx_half;
    } dbgsp_rate_s;

    dbgsp_rate_s s_q, s_d;
    logic [1:0] pre_lim;
    logic fix_tick;
    logic t1_tx;
    logic t1_rx;

    assign pre_lim = rate_double_i ? dbgsp_pkg::FIX_PRE_FAST
                                   : dbgsp_pkg::FIX_PRE_SLOW;
    assign fix_tick = (s_q.pre == pre_lim);
    // timer 1 is halved unless the rate is doubled
    assign t1_tx = t1_ovf_i & (rate_double_i | s_q.t1_tx_half);
    assign t1_rx = t1_ovf_i & (rate_double_i | s_q.t1_rx_half);

    always_comb begin
        s_d = s_q;
        s_d.pre = fix_tick ? 2'h0 : s_q.pre + 2'h1;
        if (t1_ovf_i) begin
            s_d.t1_tx_half = ~s_q.t1_tx_half;
            s_d.t1_rx_half = ~s_q.t1_rx_half;
        end
    end

    always_comb begin
        case (mode_i)
            dbgsp_pkg::MODE_9FIX: begin
                tick.tx_tick = fix_tick;
                tick.rx_tick = fix_tick;
            end
            dbgsp_pkg::MODE_8VAR, dbgsp_pkg::MODE_9VAR: begin
                tick.tx_tick = tx_second_general_timer_i ? t2_ovf_i : t1_tx;
                tick.rx_tick = rx_second_general_timer_i ? t2_ovf_i : t1_rx;
            end
            default: begin
                tick.tx_tick = 1'b0;
                tick.rx_tick = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // dbgsp_rate_gen

/* test/dbgsp_chk.sv */
// assertion checker on the debug serial port top ports
module dbgsp_chk (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    // serial pins
    input wire logic rxd_o,
    input wire logic rxd_oe_o,
    input wire logic txd_o
);
    localparam logic [7:0] CA = dbgsp_pkg::CTRL_ADDR;
    localparam logic [7:0] DA = dbgsp_pkg::DATA_ADDR;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [5:0] oe_cnt;
    } dbgsp_chk_s;
    dbgsp_chk_s st_q, st_d;
    // shadow of firmware-only control bits; hardware never writes them
    always_comb begin
        st_d = st_q;
        if (sfr_wr_i && sfr_addr_i == CA) begin
            st_d.ctrl = sfr_wdata_i;
        end
        st_d.oe_cnt = rxd_oe_o ? st_q.oe_cnt + 6'h01 : 6'h00;
        if (reset_i) begin
            st_d = '0;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        st_q <= st_d;
    end
    default clocking dcb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    buf_start_a: assert property (
        sfr_wr_i && sfr_addr_i == DA && st_q.ctrl[7:6] != 2'h0
        |=> !txd_o) else $error("no start bit after buffer write");
    shift_drive_a: assert property (
        sfr_wr_i && sfr_addr_i == DA && st_q.ctrl[7:6] == 2'h0
        |=> rxd_oe_o && rxd_o == $past(sfr_wdata_i[0]))
        else $error("shift mode does not drive first bit");
    shift_clock_a: assert property (
        st_q.ctrl[7:6] == 2'h0 && $fell(txd_o)
        |-> !txd_o [*3] ##1 txd_o [*3])
        else $error("shift clock not three low three high");
    shift_len_a: assert property (
        $fell(rxd_oe_o) |-> st_q.oe_cnt == 6'h30)
        else $error("shift transmit not 48 clocks");
    async_release_a: assert property (
        st_q.ctrl[7:6] != 2'h0 |-> !rxd_oe_o)
        else $error("receive pin driven in async mode");
    rdata_hold_a: assert property (
        !sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without read");
    unmapped_rd_a: assert property (
        sfr_rd_i && sfr_addr_i != CA && sfr_addr_i != DA
        |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
    ctrl_read_a: assert property (
        sfr_rd_i && sfr_addr_i == CA
        |=> sfr_rdata_o[7:3] == st_q.ctrl[7:3])
        else $error("firmware control bits altered");
endmodule // dbgsp_chk

bind dbgsp_top dbgsp_chk i_dbgsp_chk (
    .ref_clk_i, .reset_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .rxd_o, .rxd_oe_o, .txd_o
);

/* test/dbgsp_host.sv */
// serial terminal model on the far side of the debug serial port
module dbgsp_host (
    // clock
    input wire logic ref_clk_i,
    // pins seen by the terminal
    input wire logic txd_i,
    input wire logic pin_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line_o = 1'b1;
    // frame bit 0 first, each held bc clocks; callers split frames
    task automatic send(input logic [10:0] f, input int lo, hi, bc);
        for (int i = lo; i <= hi; i++) begin
            line_o <= f[i];
            repeat (bc) @(posedge ref_clk_i);
        end
    endtask
    // mid-bit sampling of an async frame, start bit first
    task automatic grab(input int bc, output logic [10:0] f);
        @(negedge txd_i);
        repeat (bc / 2) @(posedge ref_clk_i);
        for (int i = 0; i < 11; i++) begin
            #1 f[i] = txd_i;
            repeat (bc) @(posedge ref_clk_i);
        end
    endtask
    // shift mode: bits 1 to 7 change while the shift clock is low
    task automatic feed(input logic [7:0] b);
        line_o <= b[0];
        for (int i = 1; i < 8; i++) begin
            @(posedge txd_i);
            @(negedge txd_i);
            line_o <= b[i];
        end
        @(posedge txd_i);
        repeat (2) @(posedge ref_clk_i);
        line_o <= ~b[7];
    endtask
    task automatic take(output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd_i);
            #1 b[i] = pin_i;
        end
    endtask
endmodule // dbgsp_host

/* test/dbgsp_bench.sv */
// self-checking bench for the debug serial port
module dbgsp_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CA = dbgsp_pkg::CTRL_ADDR;
    localparam logic [7:0] DA = dbgsp_pkg::DATA_ADDR;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic t1_ovf_i = 1'b0;
    logic t2_ovf_i = 1'b0;
    logic tx_second_general_timer_i = 1'b0;
    logic rx_second_general_timer_i = 1'b0;
    logic rate_double_i = 1'b0;
    logic [7:0] sfr_rdata_o;
    logic rxd_o, rxd_oe_o, txd_o, host_line, rxd_i;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] rnd = 32'h396D87E4;
    logic [2:0] ph = 3'h0;
    logic ri_e = 1'b0;
    logic rb8_e = 1'b0;
    logic [7:0] buf_e = 8'h00;

    // shared pin: device drive wins, else the terminal
    assign rxd_i = rxd_oe_o ? rxd_o : host_line;
    always #25 ref_clk_i = ~ref_clk_i;

    dbgsp_top i_dbgsp_top (
        .ref_clk_i, .reset_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
        .sfr_wdata_i, .sfr_rdata_o, .t1_ovf_i, .t2_ovf_i, .tx_second_general_timer_i,
        .rx_second_general_timer_i, .rate_double_i, .rxd_i, .rxd_o, .rxd_oe_o, .txd_o
    );
    dbgsp_host i_dbgsp_host (
        .ref_clk_i, .txd_i(txd_o), .pin_i(rxd_i), .line_o(host_line)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // timer overflows: first timer every 2 clocks, second every 3
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
        t1_ovf_i <= ph[0];
        t2_ovf_i <= (ph == 3'h0) || (ph == 3'h3);
        if (cyc == 60000) begin
            mismatches++;
            complete_run();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic int bit_clks(input logic [1:0] m, input logic t2, rd);
        if (m == dbgsp_pkg::MODE_9FIX || !t2) return rd ? 32 : 64;
        return 48;
    endfunction

    task automatic chk(input logic [7:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        sfr_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        sfr_rd_i <= 1'b0;
        #1 d = sfr_rdata_o;
    endtask
    // polls a control bit; bounded so a stuck flag cannot hang
    task automatic wait_flag(input int b, output int n);
        logic [7:0] v;
        int t0;
        t0 = cyc;
        do begin
            rd(CA, v);
        end while (v[b] !== 1'b1 && cyc - t0 < 2000);
        n = cyc - t0;
    endtask

    task automatic tx_case(input logic [1:0] m);
        logic [7:0] b, v;
        logic [10:0] f;
        int bc, n, x;
        rnd = lfsr(rnd);
        b = rnd[7:0];
        tx_second_general_timer_i <= rnd[9];
        rate_double_i <= rnd[10];
        bc = bit_clks(m, rnd[9], rnd[10]);
        x = (m == 2'h1 ? 9 : 10) * bc;
        wr(CA, {m, 2'b00, rnd[8], 3'b000});
        fork
            i_dbgsp_host.grab(bc, f);
            begin
                wr(DA, b);
                wait_flag(1, n);
            end
        join
        chk(f[8:1], b, "tx data");
        chk({5'h00, f[10:9], f[0]},
            {5'h00, 1'b1, (m == 2'h1) | rnd[8], 1'b0}, "tx framing");
        chk({7'h00, n >= x - 2 && n <= x + 8}, 8'h01, "tx done time");
        repeat (bc) @(posedge ref_clk_i);
        rd(CA, v);
        chk(v, {m, 2'b00, rnd[8], 3'b010}, "tx status");
    endtask

    task automatic rx_case(input int i);
        logic [1:0] m;
        logic [7:0] v;
        logic [10:0] f;
        logic mpf, ren, acc;
        int bc;
        rnd = lfsr(rnd);
        m = 2'(1 + i % 3);
        mpf = i[0] ^ i[2];
        ren = (i != 5);
        f = {1'b1, i[1], rnd[7:0], 1'b0};
        rx_second_general_timer_i <= rnd[9];
        rate_double_i <= rnd[10];
        bc = bit_clks(m, rnd[9], rnd[10]);
        ri_e = (i % 4 == 3) & ri_e;
        wr(CA, {m, mpf, ren, 1'b0, rb8_e, 1'b0, ri_e});
        acc = ren && !ri_e && !(mpf && !f[9]);
        i_dbgsp_host.send(f, 0, 8, bc);
        rd(CA, v);
        chk(v, {m, mpf, ren, 1'b0, rb8_e, 1'b0, ri_e}, "rx early");
        i_dbgsp_host.send(f, 9, 9, bc);
        rb8_e = acc ? f[9] : rb8_e;
        buf_e = acc ? f[8:1] : buf_e;
        ri_e = ri_e | acc;
        rd(CA, v);
        chk(v, {m, mpf, ren, 1'b0, rb8_e, 1'b0, ri_e}, "rx flags");
        i_dbgsp_host.send(f, 10, 10, bc);
        rd(DA, v);
        chk(v, buf_e, "rx buffer");
    endtask

    initial begin
        logic [7:0] v;
        int n;
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(CA, v);
        chk(v, 8'h00, "control reset");
        rd(DA, v);
        chk(v, 8'h00, "buffer reset");
        rd(8'h9A, v);
        chk(v, 8'h00, "unmapped read");
        for (int i = 0; i < 6; i++) begin
            tx_case(2'(1 + i % 3));
        end
        for (int i = 0; i < 16; i++) begin
            rx_case(i);
        end
        rnd = lfsr(rnd);
        wr(CA, 8'h00);
        wr(DA, rnd[7:0]);
        i_dbgsp_host.take(v);
        chk(v, rnd[7:0], "shift tx data");
        repeat (8) @(posedge ref_clk_i);
        rd(CA, v);
        chk(v, 8'h02, "shift tx done");
        // filter set and rb8 set: neither may matter in shift mode
        rnd = lfsr(rnd);
        wr(CA, 8'h34);
        fork
            i_dbgsp_host.feed(rnd[7:0]);
            wait_flag(0, n);
        join
        chk({7'h00, n >= 48 && n <= 64}, 8'h01, "shift rx time");
        rd(DA, v);
        chk(v, rnd[7:0], "shift rx data");
        rd(CA, v);
        chk(v, 8'h35, "shift rx status");
        wr(CA, 8'h00);
        complete_run();
    end
endmodule // dbgsp_bench
